//--- hw/power_energy_calc_engine.sv
// measurement sequencer and background current, power, energy and charge engine
// What this block does
// - each shunt conversion end computes current and adds to charge
// - each bus conversion end computes power and adds to energy
// - power uses the last computed current and the newest bus sample
// - zero shunt calibration reports power, energy and charge as zero
// - with single-sample averaging, outputs load directly at each conversion end
// - with averaging, samples go to averaging sums, not outputs
// - each new current, voltage and temperature value adds into its sum
// - after the last sample, average, compute power, load all outputs
// - energy and charge accumulate every conversion regardless of averaging
// - energy and charge are never averaged
// - arithmetic happens at the conversion-end edge, adding no conversion time
// - one shared converter, inputs selected one at a time by a mux
// - continuous or triggered operation chosen by a control bit
// - time codes 0..7 give 50,84,150,280,540,1052,2074,4120 us
//
// Implementation choices: the register offsets and the APB register port.
module power_energy_calc_engine
  import power_engine_pkg::*;
#(
  parameter int unsigned CT_CYCLES [8] = '{ct_cycles(CT_US[0]), ct_cycles(CT_US[1]),
    ct_cycles(CT_US[2]), ct_cycles(CT_US[3]), ct_cycles(CT_US[4]), ct_cycles(CT_US[5]),
    ct_cycles(CT_US[6]), ct_cycles(CT_US[7])}
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ADC_W-1:0] adc_data,
  output logic [1:0] adc_sel,
  output logic adc_busy
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // lowest-numbered enabled channel, shunt when none
  function automatic logic [1:0] first_en(input logic [2:0] en);
    logic [1:0] r;
    r = CH_SHUNT;
    for (int i = 2; i >= 0; i--)
    begin
      if (en[i])
        r = 2'(i);
    end
    return r;
  endfunction

  // next enabled channel after ch, top bit flags wrap to a new cycle
  function automatic logic [2:0] next_en(input logic [1:0] ch, input logic [2:0] en);
    logic [2:0] r;
    r = {1'b1, first_en(en)};
    for (int i = 2; i >= 0; i--)
    begin
      if (i > int'(ch) && en[i])
        r = {1'b0, 2'(i)};
    end
    return r;
  endfunction

  // scaled current from shunt sample and calibration
  function automatic logic signed [CUR_W-1:0] cur_calc(input logic signed [ADC_W-1:0] v,
                                                      input logic [CAL_W-1:0] cal);
    logic signed [ADC_W+CAL_W:0] p;
    p = v * $signed({1'b0, cal});
    return p[CUR_SHIFT +: CUR_W];
  endfunction

  // power magnitude from current and bus voltage
  function automatic logic [PWR_W-1:0] pwr_calc(input logic signed [CUR_W-1:0] cur,
                                               input logic [ADC_W-1:0] vbus);
    logic [CUR_W-1:0] mag;
    logic [CUR_W+ADC_W-1:0] p;
    mag = cur[CUR_W-1] ? CUR_W'(-cur) : CUR_W'(cur);
    p = mag * vbus;
    return p[PWR_SHIFT +: PWR_W];
  endfunction

  // divide a sum by the power-of-two sample count
  function automatic logic signed [CSUM_W-1:0] avg_div(input logic signed [CSUM_W-1:0] s,
                                                      input logic [AVG_EXP_W-1:0] e);
    return s >>> e;
  endfunction

  // ---------------------------------------------------------------
  // register file and apb decode
  // ---------------------------------------------------------------
  logic [4:0] ctrl_q;
  logic [12:0] timing_q;
  logic [CAL_W-1:0] cal_q;
  logic ready_q;
  logic [31:0] prdata_q;
  logic [ADDR_W-1:0] addr;
  logic acc_phase;
  logic mapped;
  logic ctrl_wr;
  logic timing_wr;
  logic status_rd;
  logic [2:0] wr_en;
  logic [AVG_EXP_W-1:0] avg_exp;
  logic [31:0] rd_mux;

  engine_state_type state_q;
  logic [1:0] ch_q;
  logic [CT_W-1:0] timer_q;
  logic [CNT_W-1:0] cyc_q;
  logic signed [CUR_W-1:0] cur_last_q;
  logic signed [CUR_W-1:0] cur_out_q;
  logic signed [ADC_W-1:0] shunt_out_q;
  logic [ADC_W-1:0] vbus_out_q;
  logic signed [ADC_W-1:0] temp_out_q;
  logic [PWR_W-1:0] pwr_out_q;
  logic signed [ACC_W-1:0] energy_q;
  logic signed [ACC_W-1:0] charge_q;
  logic signed [CSUM_W-1:0] cur_sum_q;
  logic signed [SUM_W-1:0] shunt_sum_q;
  logic [SUM_W-1:0] vbus_sum_q;
  logic signed [SUM_W-1:0] temp_sum_q;

  assign addr = paddr[ADDR_W-1:0];
  assign acc_phase = psel && penable;
  assign wr_en = ctrl_q[CTRL_EN_LSB +: 3];

  // unmapped addresses answer with an error, upper address bits must be zero
  always_comb
  begin
    mapped = (paddr[31:ADDR_W] == '0) && (addr[1:0] == 2'h0) && (addr <= OFS_VSHUNT);
  end

  assign ctrl_wr = acc_phase && pwrite && mapped && (addr == OFS_CTRL) && pstrb[0];
  assign timing_wr = acc_phase && pwrite && mapped && (addr == OFS_TIMING);
  assign status_rd = acc_phase && !pwrite && mapped && (addr == OFS_STATUS);
  assign pready = acc_phase;
  assign pslverr = acc_phase && !mapped;
  assign prdata = prdata_q;

  // clamp the averaging exponent, largest count is 1024 samples
  assign avg_exp = (timing_q[TIM_AVG_LSB +: AVG_EXP_W] > AVG_MAX_EXP) ?
                   AVG_MAX_EXP : timing_q[TIM_AVG_LSB +: AVG_EXP_W];

  // configuration registers, byte strobes honoured per lane
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RESET;
      timing_q <= TIMING_RESET;
      cal_q <= CAL_RESET;
    end
    else if (acc_phase && pwrite && mapped)
    begin
      if (addr == OFS_CTRL && pstrb[0])
        ctrl_q <= {1'b0, pwdata[3:0]}; // clear bit is a command, never stored
      else if (addr == OFS_TIMING)
      begin
        if (pstrb[0])
          timing_q[7:0] <= pwdata[7:0];
        if (pstrb[1])
          timing_q[12:8] <= pwdata[12:8];
      end
      else if (addr == OFS_SHUNT_CAL)
      begin
        if (pstrb[0])
          cal_q[7:0] <= pwdata[7:0];
        if (pstrb[1])
          cal_q[14:8] <= pwdata[14:8];
      end
    end
  end

  // read mux; power, energy and charge gated to zero while calibration is zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr == OFS_CTRL)
      rd_mux = {27'h0, ctrl_q};
    else if (addr == OFS_TIMING)
      rd_mux = {19'h0, timing_q};
    else if (addr == OFS_SHUNT_CAL)
      rd_mux = {17'h0, cal_q};
    else if (addr == OFS_STATUS)
      rd_mux = {30'h0, (state_q == st_conv), ready_q};
    else if (addr == OFS_CURRENT)
      rd_mux = 32'(cur_out_q);
    else if (addr == OFS_VBUS)
      rd_mux = {12'h000, vbus_out_q};
    else if (addr == OFS_DIETEMP)
      rd_mux = 32'(temp_out_q);
    else if (addr == OFS_POWER)
      rd_mux = (cal_q == '0) ? 32'h0000_0000 : {8'h00, pwr_out_q};
    else if (addr == OFS_ENERGY)
      rd_mux = (cal_q == '0) ? 32'h0000_0000 : 32'(energy_q);
    else if (addr == OFS_CHARGE)
      rd_mux = (cal_q == '0) ? 32'h0000_0000 : 32'(charge_q);
    else if (addr == OFS_VSHUNT)
      rd_mux = 32'(shunt_out_q);
  end

  // read data captured in the setup phase, so it is flopped by the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_q <= mapped ? rd_mux : 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  logic conv_end;
  logic [2:0] nxt;
  logic cycle_end;
  logic avg_done;
  logic [2:0] new_en;
  logic [1:0] new_first;
  logic [CT_W-1:0] ct_next;

  assign conv_end = (state_q == st_conv) && (timer_q == '0);
  assign nxt = next_en(ch_q, wr_en);
  assign cycle_end = conv_end && nxt[2];
  assign avg_done = cycle_end && (cyc_q == CNT_W'((1 << avg_exp) - 1));
  assign new_en = pwdata[CTRL_EN_LSB +: 3];
  assign new_first = first_en(new_en);
  assign adc_sel = ch_q;
  assign adc_busy = (state_q == st_conv);

  // per-channel conversion length from its own time code
  function automatic logic [CT_W-1:0] ct_load(input logic [1:0] ch, input logic [12:0] tim);
    logic [CT_FIELD_W-1:0] code;
    code = tim[TIM_SH_LSB +: CT_FIELD_W];
    if (ch == CH_BUS)
      code = tim[TIM_BUS_LSB +: CT_FIELD_W];
    else if (ch == CH_TEMP)
      code = tim[TIM_TEMP_LSB +: CT_FIELD_W];
    return CT_W'(CT_CYCLES[code] - 1);
  endfunction

  assign ct_next = ct_load(nxt[1:0], timing_q);

  // a control write aborts and restarts, or stops when no input is enabled; triggered mode stops after one full average
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= st_idle;
      ch_q <= CH_SHUNT;
      timer_q <= '0;
      cyc_q <= '0;
    end
    else if (ctrl_wr)
    begin
      ch_q <= new_first;
      timer_q <= ct_load(new_first, timing_q);
      cyc_q <= '0;
      state_q <= (new_en != 3'h0) ? st_conv : st_idle;
    end
    else if (state_q == st_conv)
    begin
      if (!conv_end)
        timer_q <= timer_q - CT_W'(1);
      else
      begin
        ch_q <= nxt[1:0];
        timer_q <= ct_next;
        if (avg_done)
          cyc_q <= '0;
        else if (cycle_end)
          cyc_q <= cyc_q + CNT_W'(1);
        if (avg_done && !ctrl_q[CTRL_CONT])
          state_q <= st_idle;
      end
    end
  end

  // ready flag: set after all conversions and averaging, set beats a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ready_q <= 1'b0;
    else if (avg_done)
      ready_q <= 1'b1;
    else if (status_rd || timing_wr || (ctrl_wr && new_en != 3'h0))
      ready_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // calculation engine
  // ---------------------------------------------------------------
  logic signed [ADC_W-1:0] sample;
  logic signed [CUR_W-1:0] cur_new;
  logic [PWR_W-1:0] pwr_new;
  logic sh_end;
  logic bus_end;
  logic tmp_end;
  logic signed [CSUM_W-1:0] cur_full;
  logic signed [SUM_W-1:0] shunt_full;
  logic [SUM_W-1:0] vbus_full;
  logic signed [SUM_W-1:0] temp_full;
  logic signed [CSUM_W-1:0] cur_avg;
  logic [CSUM_W-1:0] vbus_avg;

  assign sample = adc_data;
  assign sh_end = conv_end && (ch_q == CH_SHUNT);
  assign bus_end = conv_end && (ch_q == CH_BUS);
  assign tmp_end = conv_end && (ch_q == CH_TEMP);
  assign cur_new = cur_calc(sample, cal_q);
  assign pwr_new = pwr_calc(cur_last_q, adc_data);

  // sums including the sample ending now, so the final load needs no extra cycle
  assign cur_full = cur_sum_q + (sh_end ? CSUM_W'(cur_new) : '0);
  assign shunt_full = shunt_sum_q + (sh_end ? SUM_W'(sample) : '0);
  assign vbus_full = vbus_sum_q + (bus_end ? SUM_W'(adc_data) : '0);
  assign temp_full = temp_sum_q + (tmp_end ? SUM_W'(sample) : '0);
  assign cur_avg = avg_div(cur_full, avg_exp);
  assign vbus_avg = avg_div($signed({4'h0, vbus_full}), avg_exp);

  // last instantaneous current, the operand for the next power product
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_last_q <= '0;
    else if (sh_end)
      cur_last_q <= cur_new;
  end

  // averaging sums; restarted on completion or on a control write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_sum_q <= '0;
      shunt_sum_q <= '0;
      vbus_sum_q <= '0;
      temp_sum_q <= '0;
    end
    else if (ctrl_wr || avg_done)
    begin
      cur_sum_q <= '0;
      shunt_sum_q <= '0;
      vbus_sum_q <= '0;
      temp_sum_q <= '0;
    end
    else if (conv_end)
    begin
      cur_sum_q <= cur_full;
      shunt_sum_q <= shunt_full;
      vbus_sum_q <= vbus_full;
      temp_sum_q <= temp_full;
    end
  end

  // output registers: direct at one sample, else loaded once per full average
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_out_q <= '0;
      shunt_out_q <= '0;
      vbus_out_q <= '0;
      temp_out_q <= '0;
      pwr_out_q <= '0;
    end
    else if (avg_exp == '0)
    begin
      if (sh_end)
      begin
        shunt_out_q <= sample;
        cur_out_q <= cur_new;
      end
      if (bus_end)
      begin
        vbus_out_q <= adc_data;
        pwr_out_q <= pwr_new;
      end
      if (tmp_end)
        temp_out_q <= sample;
    end
    else if (avg_done)
    begin
      cur_out_q <= cur_avg[CUR_W-1:0];
      shunt_out_q <= ADC_W'(avg_div(CSUM_W'(shunt_full), avg_exp));
      vbus_out_q <= vbus_avg[ADC_W-1:0];
      temp_out_q <= ADC_W'(avg_div(CSUM_W'(temp_full), avg_exp));
      pwr_out_q <= pwr_calc(cur_avg[CUR_W-1:0], vbus_avg[ADC_W-1:0]);
    end
  end

  // accumulators take every conversion, unaveraged, in the same edge as the result
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      energy_q <= '0;
      charge_q <= '0;
    end
    else if (ctrl_wr && pwdata[CTRL_ACC_CLR])
    begin
      energy_q <= '0;
      charge_q <= '0;
    end
    else if (cal_q == '0)
    begin
      energy_q <= '0;
      charge_q <= '0;
    end
    else
    begin
      if (bus_end)
        energy_q <= energy_q + ACC_W'(pwr_new);
      if (sh_end)
        charge_q <= charge_q + ACC_W'(cur_new);
    end
  end

endmodule

//--- hw/power_engine_pkg.sv
// constants and types shared by the power, energy and charge calculation engine
package power_engine_pkg;

  // ---------------------------------------------------------------
  // clock and conversion timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 25000;
  localparam int unsigned US_PER_MS = 1000;
  localparam int unsigned CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam int unsigned CT_W = 17;

  // exact cycle count for a conversion time in microseconds
  function automatic int unsigned ct_cycles(input int unsigned us);
    return (us * CLK_FREQ_KHZ) / US_PER_MS;
  endfunction

  // ---------------------------------------------------------------
  // data widths and arithmetic scaling
  // ---------------------------------------------------------------
  localparam int unsigned ADC_W = 20;
  localparam int unsigned CAL_W = 15;
  localparam int unsigned CUR_W = 24;
  localparam int unsigned PWR_W = 24;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned AVG_EXP_W = 4;
  localparam int unsigned CNT_W = 11;
  localparam int unsigned SUM_W = ADC_W + 10;
  localparam int unsigned CSUM_W = CUR_W + 10;
  localparam int unsigned CUR_SHIFT = 11;
  localparam int unsigned PWR_SHIFT = 20;
  localparam logic [AVG_EXP_W-1:0] AVG_MAX_EXP = 4'hA;

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMING = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SHUNT_CAL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VBUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DIETEMP = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_POWER = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_ENERGY = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CHARGE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_VSHUNT = 8'h28;

  // control fields
  localparam int unsigned CTRL_EN_LSB = 0;
  localparam int unsigned CTRL_CONT = 3;
  localparam int unsigned CTRL_ACC_CLR = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // timing fields
  localparam int unsigned CT_FIELD_W = 3;
  localparam int unsigned TIM_SH_LSB = 0;
  localparam int unsigned TIM_BUS_LSB = 3;
  localparam int unsigned TIM_TEMP_LSB = 6;
  localparam int unsigned TIM_AVG_LSB = 9;
  localparam logic [12:0] TIMING_RESET = 13'h0DB6;
  localparam logic [CAL_W-1:0] CAL_RESET = 15'h0000;
  // status fields
  localparam int unsigned ST_READY = 0;
  localparam int unsigned ST_BUSY = 1;

  // ---------------------------------------------------------------
  // multiplexer channels and engine states
  // ---------------------------------------------------------------
  localparam logic [1:0] CH_SHUNT = 2'h0;
  localparam logic [1:0] CH_BUS = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;

  typedef enum logic {st_idle, st_conv} engine_state_type;

endpackage

//--- tb/power_energy_calc_engine_properties.sv
// port-level assertions for the calculation engine, bound to the top module
module power_energy_calc_engine_properties
  import power_engine_pkg::*;
#(
  parameter int unsigned CT_CYCLES [8] = '{2, 3, 4, 5, 6, 7, 8, 9}
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ADC_W-1:0] adc_data,
  input wire logic [1:0] adc_sel,
  input wire logic adc_busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic [2:0] en_q;
  logic [12:0] tim_q;
  logic [1:0] sel_q;
  logic busy_q;
  logic dirty_q;
  logic [16:0] cnt_q;
  logic wr_now;
  logic bad_addr;
  logic ctrl_wr;
  logic cfg_wr;
  logic restart;

  // a write to control or timing spoils the running conversion for checking
  assign wr_now = psel & penable & pwrite & pready;
  assign bad_addr = (paddr[31:8] != 24'h000000) || (paddr[1:0] != 2'h0) ||
                    (paddr[7:0] > OFS_VSHUNT);
  assign ctrl_wr = wr_now && !bad_addr && pstrb[0] && (paddr[7:0] == OFS_CTRL);
  assign cfg_wr = wr_now && !bad_addr && (paddr[7:0] == OFS_CTRL || paddr[7:0] == OFS_TIMING);
  assign restart = adc_busy & (~busy_q | (adc_sel != sel_q));

  // next enabled channel after cur in shunt, bus, temperature order
  function automatic logic [1:0] next_ch(input logic [1:0] cur, input logic [2:0] en);
    logic [1:0] c;
    c = cur;
    for (int i = 0; i < 3; i++)
    begin
      c = (c == 2'h2) ? 2'h0 : c + 2'h1;
      if (en[c])
        return c;
    end
    return cur;
  endfunction

  function automatic int unsigned ct_of(input logic [1:0] ch);
    return CT_CYCLES[tim_q[(3 * ch) +: 3]];
  endfunction

  // shadow copies of enables and time codes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 3'h0;
      tim_q <= TIMING_RESET;
    end
    else if (ctrl_wr)
      en_q <= pwdata[2:0];
    else if (cfg_wr && pstrb[1:0] == 2'h3 && paddr[7:0] == OFS_TIMING)
      tim_q <= pwdata[12:0];
  end

  // length of the current conversion in cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= 2'h0;
      busy_q <= 1'b0;
      cnt_q <= 17'h00000;
      dirty_q <= 1'b1;
    end
    else
    begin
      sel_q <= adc_sel;
      busy_q <= adc_busy;
      cnt_q <= restart ? 17'h00001 : cnt_q + 17'h00001;
      dirty_q <= cfg_wr ? 1'b1 : (restart ? 1'b0 : dirty_q);
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_err_map: assert property (psel && penable |-> pslverr == bad_addr)
    else $error("pslverr does not match address map");
  chk_rdata_bad: assert property (psel && !penable && !pwrite && bad_addr |=> prdata == 32'h0)
    else $error("read data not zero for unmapped read");
  chk_sel_legal: assert property (adc_sel != 2'h3)
    else $error("illegal mux select");
  chk_start_first: assert property (
    ctrl_wr && pwdata[2:0] != 3'h0 |=> adc_busy && adc_sel == next_ch(2'h2, en_q))
    else $error("conversion did not start on first enabled input");
  chk_stop_idle: assert property (ctrl_wr && pwdata[2:0] == 3'h0 |=> !adc_busy [*2])
    else $error("converter busy after shutdown");
  chk_conv_length: assert property (
    busy_q && (!adc_busy || adc_sel != sel_q) && !dirty_q |-> 32'(cnt_q) == ct_of(sel_q))
    else $error("conversion length wrong for time code");
  chk_chan_order: assert property (
    busy_q && adc_busy && adc_sel != sel_q && !dirty_q |-> adc_sel == next_ch(sel_q, en_q))
    else $error("input conversion order wrong");
endmodule

bind power_energy_calc_engine
  power_energy_calc_engine_properties #(.CT_CYCLES(CT_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .adc_data(adc_data), .adc_sel(adc_sel), .adc_busy(adc_busy));

//--- tb/tb_power_energy_calc_engine.sv
// self-checking testbench for the calculation engine over its register bus
module tb_power_energy_calc_engine
  import power_engine_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // short conversion times keep the run brief
  localparam int unsigned CT_SMALL [8] = '{2, 3, 4, 5, 6, 7, 8, 9};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, adc_busy, err;
  logic [ADC_W-1:0] adc_data = 20'h00000;
  logic [1:0] adc_sel;
  logic [1:0] sel_seen = 2'h0;
  logic pass_odd = 1'b0;
  logic vary = 1'b0;
  logic [31:0] rd;
  longint unsigned exp_pw, exp_en;
  int failures = 0;
  int checks_done = 0;

  power_energy_calc_engine #(.CT_CYCLES(CT_SMALL)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_data(adc_data), .adc_sel(adc_sel), .adc_busy(adc_busy));

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // converter stand-in: fixed level per input, odd passes add two
  // ---------------------------------------------------------------
  function automatic logic [ADC_W-1:0] base_val(input logic [1:0] s);
    return (s == CH_SHUNT) ? 20'h01000 : ((s == CH_BUS) ? 20'h40000 : 20'h00100);
  endfunction

  // parity flips on entry to shunt, so two passes differ whenever shunt and another input are both enabled
  always @(posedge pclk)
  begin
    sel_seen <= adc_sel;
    if (adc_sel == CH_SHUNT && sel_seen != CH_SHUNT)
      pass_odd <= ~pass_odd;
    adc_data <= base_val(adc_sel) + ((vary && pass_odd) ? 20'h00002 : 20'h00000);
  end

  // ---------------------------------------------------------------
  // bus tasks and comparison
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // entered just after a rising edge; leaves one idle cycle behind it
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    check(rd, e);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (adc_busy !== 1'b0 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    check({31'h00000000, adc_busy}, 32'h00000000);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog, well past the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, read-only result, refused addresses
    rd_chk(OFS_CTRL, 32'h00000000);
    rd_chk(OFS_TIMING, 32'h00000DB6);
    for (int a = 8; a <= 40; a += 4)
      rd_chk(ADDR_W'(a), 32'h00000000);
    apb(1'b1, OFS_CURRENT, 32'h12345678);
    rd_chk(OFS_CURRENT, 32'h00000000);
    rd_chk(8'h2C, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    apb(1'b0, 8'h02, 32'h00000000);
    check({31'h00000000, err}, 32'h00000001);
    // zero calibration, one sample, triggered
    apb(1'b1, OFS_TIMING, 32'h000000DB);
    apb(1'b1, OFS_CTRL, 32'h00000003);
    wait_idle();
    rd_chk(OFS_POWER, 32'h00000000);
    rd_chk(OFS_ENERGY, 32'h00000000);
    rd_chk(OFS_CHARGE, 32'h00000000);
    rd_chk(OFS_VBUS, 32'h00040000);
    // calibration 2048 makes current equal the shunt code
    apb(1'b1, OFS_SHUNT_CAL, 32'h00000800);
    apb(1'b1, OFS_CTRL, 32'h00000003);
    wait_idle();
    rd_chk(OFS_CURRENT, 32'h00001000);
    rd_chk(OFS_VSHUNT, 32'h00001000);
    rd_chk(OFS_CHARGE, 32'h00001000);
    rd_chk(OFS_POWER, 32'h00000400);
    rd_chk(OFS_ENERGY, 32'h00000400);
    rd_chk(OFS_STATUS, 32'h00000001);
    // results were nonzero, so a zero calibration must now hide them
    apb(1'b1, OFS_SHUNT_CAL, 32'h00000000);
    rd_chk(OFS_POWER, 32'h00000000);
    rd_chk(OFS_CHARGE, 32'h00000000);
    apb(1'b1, OFS_SHUNT_CAL, 32'h00000800);
    // two-sample average over all inputs, accumulators cleared first
    apb(1'b1, OFS_CTRL, 32'h00000010);
    apb(1'b1, OFS_TIMING, 32'h000002DB);
    vary <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h00000007);
    repeat (14) @(posedge pclk);
    rd_chk(OFS_DIETEMP, 32'h00000000);
    wait_idle();
    exp_pw = (64'h1001 * 64'h40001) >> 20;
    exp_en = ((64'h1000 * 64'h40000) >> 20) + ((64'h1002 * 64'h40002) >> 20);
    rd_chk(OFS_CURRENT, 32'h00001001);
    rd_chk(OFS_VSHUNT, 32'h00001001);
    rd_chk(OFS_VBUS, 32'h00040001);
    rd_chk(OFS_DIETEMP, 32'h00000101);
    rd_chk(OFS_POWER, 32'(exp_pw));
    rd_chk(OFS_ENERGY, 32'(exp_en));
    rd_chk(OFS_CHARGE, 32'h00002002);
    // every shunt time code once, one sample each
    vary <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, OFS_TIMING, 32'(k));
      apb(1'b1, OFS_CTRL, 32'h00000001);
      wait_idle();
    end
    rd_chk(OFS_CHARGE, 32'h0000A002);
    // continuous mode keeps converting until shutdown
    apb(1'b1, OFS_CTRL, 32'h00000009);
    repeat (40) @(posedge pclk);
    check({31'h00000000, adc_busy}, 32'h00000001);
    apb(1'b0, OFS_CHARGE, 32'h00000000);
    check({31'h00000000, (rd > 32'hA002) && ((rd - 32'hA002) % 32'h1000 == 0)}, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    check({31'h00000000, adc_busy}, 32'h00000000);
    report_and_stop();
  end
endmodule
